// >>> logic/swe_pkg.sv
// Constants shared by the serial EEPROM port design.
// Functional notes
// - Strap high gives 16-bit words, low 8-bit.
// - Unconnected strap defaults to 16-bit words.
// - Respond only while chip select is asserted.
// - Read decodes address, shifts stored word out.
// - Self-timed write within 5 ms, no pre-erase.
// - Programming only in enabled state, else ignored.
// - After write start, output shows ready/busy.
// - Instruction: start bit 1, opcode, address, data.
// - Opcodes: 10 read, 01 write, 11 erase.
// - Opcode 00: address top bits pick command.
// - Address 9 or 8 bits; data 8/16.
package swe_pkg;
   localparam int          SYNC_W         = 4;     // Synchronised pins.
   localparam int          CLK_PERIOD_NS  = 5;     // Core clock period.
   localparam int          WRITE_TIME_MS  = 5;     // Longest write time.
   // Longest time, so the division rounds down.
   localparam int          WRITE_CYCLES   =
      WRITE_TIME_MS * 1000000 / CLK_PERIOD_NS;
   localparam int          BUSY_W         = 20;    // Busy counter width.
   localparam int          BYTES          = 512;   // Array size in bytes.
   localparam logic [4:0]  ADDR_LEN_X8    = 5'h09; // Address bits, x8.
   localparam logic [4:0]  ADDR_LEN_X16   = 5'h08; // Address bits, x16.
   localparam logic [4:0]  WORD_LEN_X8    = 5'h08; // Data bits, x8.
   localparam logic [4:0]  WORD_LEN_X16   = 5'h10; // Data bits, x16.
   localparam logic        ORG_RESET      = 1'h1;  // Pull-up default.
   localparam logic [1:0]  OP_EXT         = 2'h0;  // Extended group.
   localparam logic [1:0]  OP_WRITE       = 2'h1;
   localparam logic [1:0]  OP_READ        = 2'h2;
   localparam logic [1:0]  OP_ERASE       = 2'h3;
   localparam logic [1:0]  EXT_DISABLE    = 2'h0;  // program_disable_cmd.
   localparam logic [1:0]  EXT_WRITE_ALL  = 2'h1;  // write_all_cmd.
   localparam logic [1:0]  EXT_ERASE_ALL  = 2'h2;  // erase_all_cmd.
   localparam logic [1:0]  EXT_ENABLE     = 2'h3;  // program_enable_cmd.
   localparam logic [15:0] ERASED_WORD    = 16'hffff;

   // Serial front end states.
   typedef enum logic [2:0] {
      ST_IDLE, ST_OPC, ST_ADDR, ST_DATA, ST_READ, ST_DONE
   } swe_state_e;
endpackage : swe_pkg

// >>> logic/swe_word_buf.sv
// Two-entry word buffer between the array fetch and the read shifter.
`timescale 1ns/1ps
module swe_word_buf (
   // Clock and reset.
   input  wire logic        clk_in,
   input  wire logic        sys_rst_in,
   input  wire logic        flush_in,
   // Filling side.
   input  wire logic        in_valid_in,
   output logic             in_ready_out,
   input  wire logic [15:0] in_data_in,
   // Draining side.
   output logic             out_valid_out,
   input  wire logic        out_ready_in,
   output logic [15:0]      out_data_out
);
   logic [15:0] slot_r [2];  // Storage for the two words.
   logic        wr_ptr_r;    // Next slot to fill.
   logic        rd_ptr_r;    // Next slot to drain.
   logic [1:0]  count_r;     // Words held, zero to two.
   logic        push;
   logic        pop;

   assign in_ready_out  = (count_r != 2'h2);
   assign out_valid_out = (count_r != 2'h0);
   assign out_data_out  = slot_r[rd_ptr_r];
   assign push          = in_valid_in && in_ready_out;
   assign pop           = out_valid_out && out_ready_in;

   // Pointers and fill level; flush drops everything held.
   always_ff @(posedge clk_in) begin
      if (sys_rst_in || flush_in) begin
         wr_ptr_r <= 1'h0;
         rd_ptr_r <= 1'h0;
         count_r  <= 2'h0;
      end else begin
         if (push) begin
            wr_ptr_r <= ~wr_ptr_r;
         end
         if (pop) begin
            rd_ptr_r <= ~rd_ptr_r;
         end
         count_r <= count_r + {1'h0, push} - {1'h0, pop};
      end
   end

   // Data storage needs no reset; only valid slots are ever read.
   always_ff @(posedge clk_in) begin
      if (push) begin
         slot_r[wr_ptr_r] <= in_data_in;
      end
   end
endmodule : swe_word_buf

// >>> logic/swe_port.sv
// Device side of the three-wire serial EEPROM: decode, array, status.
`timescale 1ns/1ps
module swe_port #(
   parameter int WRITE_CYCLES = swe_pkg::WRITE_CYCLES
) (
   // Clock and reset.
   input  wire logic clk_in,
   input  wire logic sys_rst_in,
   // Serial pins from the host.
   input  wire logic chip_select_in,
   input  wire logic shift_clock_in,
   input  wire logic serial_in,
   input  wire logic word_width_strap_in,
   // Serial output pin with its enable.
   output logic      serial_out,
   output logic      serial_out_oe_out
);
   import swe_pkg::*;

   logic [SYNC_W-1:0] meta_r;      // First synchroniser stage.
   logic [SYNC_W-1:0] sync_r;      // Second synchroniser stage.
   logic              sk_d_r;      // Delayed shift clock for edges.
   logic              cs_s, sk_s, di_s, strap_s;
   logic              sk_rise;
   swe_state_e        state_r;
   logic [4:0]        cnt_r;       // Bits left in the current field.
   logic [1:0]        op_r;
   logic [8:0]        addr_r;
   logic [15:0]       data_r;
   logic [8:0]        addr_nxt;
   logic [15:0]       data_nxt;
   logic              org_r;       // 1 = 16-bit words.
   logic [4:0]        addr_len, word_len;
   logic              prog_en_r;   // Programming enabled.
   logic              busy_r;
   logic [BUSY_W-1:0] busy_cnt_r;
   logic              status_r;    // Output shows ready/busy.
   logic              addr_done, data_done;
   logic              wr_go, wr_all;
   logic [15:0]       wr_val;
   logic [8:0]        wr_addr;     // Target of a single-location write.
   logic [1:0]        ext_cmd;
   logic [7:0]        mem [BYTES];
   logic              fetch_on_r;
   logic [8:0]        fetch_addr_r;
   logic [15:0]       fetch_word;
   logic              buf_in_ready, buf_out_valid, pop;
   logic [15:0]       buf_out_data;
   logic [15:0]       shift_r;
   logic [4:0]        bits_left_r;
   logic              out_bit_r;
   logic              serial_out_r;
   logic              oe_r;

   // Two flip-flops on every pin before any logic looks at it.
   for (genvar i = 0; i < SYNC_W; i++) begin : g_sync
      always_ff @(posedge clk_in) begin
         if (sys_rst_in) begin
            // The strap stages rest at the pull-up level, so the x16
            // default is not lost for two cycles after reset.
            meta_r[i] <= (i == 3) ? ORG_RESET : 1'h0;
            sync_r[i] <= (i == 3) ? ORG_RESET : 1'h0;
         end else begin
            meta_r[i] <= (i == 0) ? chip_select_in :
                         (i == 1) ? shift_clock_in :
                         (i == 2) ? serial_in : word_width_strap_in;
            sync_r[i] <= meta_r[i];
         end
      end
   end
   assign cs_s    = sync_r[0];
   assign sk_s    = sync_r[1];
   assign di_s    = sync_r[2];
   assign strap_s = sync_r[3];

   // Edge finder works on the second stage only.
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         sk_d_r <= 1'h0;
      end else begin
         sk_d_r <= sk_s;
      end
   end
   assign sk_rise = cs_s && sk_s && !sk_d_r;

   // The strap is caught only between frames so a frame never sees
   // the organisation change under it. Reset value is the x16 default.
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         org_r <= ORG_RESET;
      end else if (!cs_s) begin
         org_r <= strap_s;
      end
   end
   assign addr_len = org_r ? ADDR_LEN_X16 : ADDR_LEN_X8;
   assign word_len = org_r ? WORD_LEN_X16 : WORD_LEN_X8;

   assign addr_nxt  = {addr_r[7:0], di_s};
   assign data_nxt  = {data_r[14:0], di_s};
   assign addr_done = (state_r == ST_ADDR) && sk_rise && (cnt_r == 5'h01);
   assign data_done = (state_r == ST_DATA) && sk_rise && (cnt_r == 5'h01);
   assign ext_cmd   = org_r ? addr_nxt[7:6] : addr_nxt[8:7];
   // An erase commits on its last address bit, so its address is still
   // being shifted; a write commits after the data field, when the
   // address register already holds the whole field.
   assign wr_addr   = (op_r == OP_ERASE) ? addr_nxt : addr_r;

   // Program start decode. Nothing starts unless programming is on,
   // and an erase simply writes the erased pattern.
   always_comb begin
      wr_go  = 1'h0;
      wr_all = 1'h0;
      wr_val = ERASED_WORD;
      if (addr_done && op_r == OP_ERASE) begin
         wr_go = prog_en_r;
      end else if (addr_done && op_r == OP_EXT
                   && ext_cmd == EXT_ERASE_ALL) begin
         wr_go  = prog_en_r;
         wr_all = 1'h1;
      end else if (data_done) begin
         wr_go  = prog_en_r;
         wr_all = (op_r == OP_EXT);
         wr_val = org_r ? data_nxt : {8'h00, data_nxt[7:0]};
      end
   end

   // Front end: start bit, opcode, address and data fields.
   always_ff @(posedge clk_in) begin
      if (sys_rst_in || !cs_s) begin
         state_r <= ST_IDLE;
         cnt_r   <= 5'h00;
         op_r    <= 2'h0;
         addr_r  <= 9'h000;
         data_r  <= 16'h0000;
      end else if (sk_rise) begin
         unique case (state_r)
            ST_IDLE: begin
               // A start bit while busy is ignored.
               if (di_s && !busy_r) begin
                  state_r <= ST_OPC;
                  cnt_r   <= 5'h02;
               end
            end
            ST_OPC: begin
               op_r  <= {op_r[0], di_s};
               cnt_r <= cnt_r - 5'h01;
               if (cnt_r == 5'h01) begin
                  state_r <= ST_ADDR;
                  cnt_r   <= addr_len;
               end
            end
            ST_ADDR: begin
               addr_r <= addr_nxt;
               cnt_r  <= cnt_r - 5'h01;
               if (cnt_r == 5'h01) begin
                  cnt_r <= word_len;
                  if (op_r == OP_READ) begin
                     state_r <= ST_READ;
                  end else if (op_r == OP_WRITE || (op_r == OP_EXT
                               && ext_cmd == EXT_WRITE_ALL)) begin
                     state_r <= ST_DATA;
                  end else begin
                     state_r <= ST_DONE;
                  end
               end
            end
            ST_DATA: begin
               data_r <= data_nxt;
               cnt_r  <= cnt_r - 5'h01;
               if (cnt_r == 5'h01) begin
                  state_r <= ST_DONE;
               end
            end
            ST_READ: begin
               state_r <= ST_READ;
            end
            ST_DONE: begin
               state_r <= ST_DONE;
            end
         endcase
      end
   end

   // Enable and disable take effect at the end of their address field.
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         prog_en_r <= 1'h0;
      end else if (addr_done && op_r == OP_EXT) begin
         if (ext_cmd == EXT_ENABLE) begin
            prog_en_r <= 1'h1;
         end else if (ext_cmd == EXT_DISABLE) begin
            prog_en_r <= 1'h0;
         end
      end
   end

   // Array update. Contents are committed at once; the busy timer that
   // follows only models the self-timed cycle seen by the host.
   always_ff @(posedge clk_in) begin
      if (wr_go) begin
         if (wr_all) begin
            for (int b = 0; b < BYTES; b++) begin
               mem[b] <= (org_r && b[0]) ? wr_val[15:8] : wr_val[7:0];
            end
         end else if (org_r) begin
            mem[{wr_addr[7:0], 1'h0}] <= wr_val[7:0];
            mem[{wr_addr[7:0], 1'h1}] <= wr_val[15:8];
         end else begin
            mem[wr_addr] <= wr_val[7:0];
         end
      end
   end

   // Self-timed write cycle and the status flag shown on the output.
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         busy_r     <= 1'h0;
         busy_cnt_r <= '0;
         status_r   <= 1'h0;
      end else begin
         if (wr_go) begin
            busy_r     <= 1'h1;
            busy_cnt_r <= BUSY_W'(WRITE_CYCLES - 1);
            status_r   <= 1'h1;
         end else begin
            if (busy_r) begin
               busy_cnt_r <= busy_cnt_r - 1'h1;
               busy_r     <= (busy_cnt_r != '0);
            end
            if (state_r == ST_IDLE && sk_rise && di_s && !busy_r) begin
               status_r <= 1'h0;
            end
         end
      end
   end

   // Read fetch: words are pushed ahead of the shifter, address rolls on.
   assign fetch_word = org_r
      ? {mem[{fetch_addr_r[7:0], 1'h1}], mem[{fetch_addr_r[7:0], 1'h0}]}
      : {mem[fetch_addr_r], 8'h00};
   always_ff @(posedge clk_in) begin
      if (sys_rst_in || !cs_s) begin
         fetch_on_r   <= 1'h0;
         fetch_addr_r <= 9'h000;
      end else if (addr_done && op_r == OP_READ) begin
         fetch_on_r   <= 1'h1;
         fetch_addr_r <= org_r ? {1'h0, addr_nxt[7:0]} : addr_nxt;
      end else if (fetch_on_r && buf_in_ready) begin
         // Wraps within the array for either organisation.
         fetch_addr_r <= org_r ? {1'h0, fetch_addr_r[7:0] + 8'h01}
                               : fetch_addr_r + 9'h001;
      end
   end

   swe_word_buf u_buf (
      .clk_in        (clk_in),
      .sys_rst_in    (sys_rst_in),
      .flush_in      (!cs_s),
      .in_valid_in   (fetch_on_r),
      .in_ready_out  (buf_in_ready),
      .in_data_in    (fetch_word),
      .out_valid_out (buf_out_valid),
      .out_ready_in  (pop),
      .out_data_out  (buf_out_data)
   );

   // The shifter stalls the fetch by taking a word only when empty.
   // An empty buffer simply holds the output bit rather than loading junk.
   assign pop = (state_r == ST_READ) && sk_rise && (bits_left_r == 5'h00)
                && buf_out_valid;

   // Read shifter: a dummy zero follows the address, then data MSB first.
   always_ff @(posedge clk_in) begin
      if (sys_rst_in || !cs_s) begin
         shift_r     <= 16'h0000;
         bits_left_r <= 5'h00;
         out_bit_r   <= 1'h0;
      end else if (addr_done) begin
         out_bit_r   <= 1'h0;
         bits_left_r <= 5'h00;
      end else if (pop) begin
         out_bit_r   <= buf_out_data[15];
         shift_r     <= {buf_out_data[14:0], 1'h0};
         bits_left_r <= word_len - 5'h01;
      end else if (state_r == ST_READ && sk_rise && bits_left_r != 5'h00) begin
         out_bit_r   <= shift_r[15];
         shift_r     <= {shift_r[14:0], 1'h0};
         bits_left_r <= bits_left_r - 5'h01;
      end
   end

   // Output pin: driven only inside a frame; status overrides data.
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         serial_out_r <= 1'h0;
         oe_r         <= 1'h0;
      end else begin
         oe_r         <= cs_s;
         serial_out_r <= status_r ? !busy_r : out_bit_r;
      end
   end
   assign serial_out        = serial_out_r;
   assign serial_out_oe_out = oe_r;

   // Checks kept beside the logic they guard.
   sequence s_go;
      wr_go;
   endsequence
   sequence s_busy_run;
      busy_r [*8];
   endsequence

   a_oe_follows_cs: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      cs_s |=> serial_out_oe_out)
      else $error("Output not enabled inside frame.");
   a_oe_off_idle: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      !cs_s |=> !serial_out_oe_out)
      else $error("Output driven outside frame.");
   a_write_gated: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      !prog_en_r && (data_done || (addr_done && (op_r == OP_ERASE
         || (op_r == OP_EXT && ext_cmd == EXT_ERASE_ALL))))
      |=> !busy_r)
      else $error("Write started while disabled.");
   a_busy_holds: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      s_go |=> s_busy_run)
      else $error("Busy ended too early.");
   a_busy_bound: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      busy_r |-> busy_cnt_r < BUSY_W'(WRITE_CYCLES))
      else $error("Busy count out of range.");
   a_status_busy: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      s_go ##1 (status_r && busy_r) |=> !serial_out)
      else $error("Busy status not low.");
   a_no_frame: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      !cs_s |=> state_r == ST_IDLE)
      else $error("Decoder active outside frame.");
   a_start_bit: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      state_r == ST_IDLE && sk_rise && !di_s |=> state_r == ST_IDLE)
      else $error("Zero taken as start bit.");
   a_read_shift: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      state_r == ST_READ && sk_rise && bits_left_r != 5'h00
      |=> out_bit_r == $past(shift_r[15]))
      else $error("Read bit not shifted out.");
   a_seq_incr: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      fetch_on_r && buf_in_ready && cs_s && !addr_done && !org_r
      |=> fetch_addr_r == $past(fetch_addr_r) + 9'h001)
      else $error("Read address did not advance.");
   a_org_width: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      $rose(cs_s) |-> org_r == $past(strap_s)
                      && word_len == (org_r ? 5'h10 : 5'h08))
      else $error("Word width does not match strap.");
endmodule : swe_port

// >>> tb/swe_host.sv
// Host-side serial master model that drives the three serial pins.
`timescale 1ns/1ps
module swe_host (
   // Core clock, used only to pace the pins.
   input  wire logic clk_in,
   // Serial pins toward the device.
   output logic      chip_select_out,
   output logic      shift_clock_out,
   output logic      serial_data_out,
   // Device output as seen on the wire.
   input  wire logic data_line_in
);
   logic last_bit_r; // Last bit driven.

   // Pins start idle, and the shift clock stays low between frames.
   initial begin
      chip_select_out = 1'b0;
      shift_clock_out = 1'b0;
      serial_data_out = 1'b1;
      last_bit_r      = 1'b0;
   end

   // Raise chip select after a low time long enough for the pin sync.
   task automatic frame_open();
      repeat (8) @(negedge clk_in);
      chip_select_out = 1'b1;
      repeat (6) @(negedge clk_in);
   endtask : frame_open

   // Drop chip select; the host data pin flips so no stale bit is seen.
   task automatic frame_close();
      chip_select_out = 1'b0;
      serial_data_out = ~last_bit_r;
      repeat (8) @(negedge clk_in);
   endtask : frame_close

   // Shift n bits MSB first; each bit spans 65 ns of shift clock.
   task automatic shift_bits(input logic [31:0] v, input int n,
                             output logic [31:0] rx);
      rx = 32'h0;
      for (int i = n - 1; i >= 0; i--) begin
         serial_data_out = v[i];
         last_bit_r      = v[i];
         repeat (6) @(negedge clk_in);
         shift_clock_out = 1'b1;
         // The device answers some cycles after the rise, so wait first.
         repeat (7) @(negedge clk_in);
         rx              = {rx[30:0], data_line_in};
         shift_clock_out = 1'b0;
      end
   endtask : shift_bits
endmodule : swe_host

// >>> tb/swe_port_test.sv
// Self-checking bench for the serial EEPROM port driven by a host model.
`timescale 1ns/1ps
module swe_port_test;
   import swe_pkg::*;
   localparam int WCYC = 40;      // Short busy time keeps the run brief.
   logic        clk_in     = 1'b0; // Core clock.
   logic        sys_rst_in = 1'b1; // Synchronous reset.
   logic        strap_r    = 1'b1; // Pull-up default modelled as high.
   logic        cs, sk, di;        // Host pins.
   logic        dout, oe;          // Device output and its enable.
   wire         do_line = oe ? dout : 1'bz; // Undriven line floats.
   int          miscompares = 0;
   int          comparisons = 0;
   int          cyc = 0;           // Cycles run so far.
   logic [31:0] rx;                // Bits returned by the last shift.

   // Half period of 2.5 ns gives 200 MHz.
   always #2.5 clk_in = ~clk_in;

   // A hang counts as a mismatch and ends the run.
   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 40000) begin
         miscompares++;
         final_report();
      end
   end

   swe_host host (
      .clk_in          (clk_in),
      .chip_select_out (cs),
      .shift_clock_out (sk),
      .serial_data_out (di),
      .data_line_in    (do_line)
   );

   swe_port #(.WRITE_CYCLES(WCYC)) dut (
      .clk_in              (clk_in),
      .sys_rst_in          (sys_rst_in),
      .chip_select_in      (cs),
      .shift_clock_in      (sk),
      .serial_in           (di),
      .word_width_strap_in (strap_r),
      .serial_out          (dout),
      .serial_out_oe_out   (oe)
   );

   // Compare four-state values and count every result.
   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // Extended command address: selector in the two leading address bits.
   function automatic logic [8:0] ext(input logic [1:0] sel);
      return strap_r ? {1'b0, sel, 6'h0} : {sel, 7'h0};
   endfunction : ext

   // Shift start bit, opcode, address and nd data bits in one go.
   task automatic instr(input logic [1:0] op, input logic [8:0] a,
                        input logic [15:0] d, input int nd);
      int          na;
      logic [31:0] v;
      na = strap_r ? 8 : 9;
      v  = (32'h1 << 2) | 32'(op);
      v  = (v << na) | 32'(a);
      v  = (v << nd) | 32'(d);
      host.shift_bits(v, 3 + na + nd, rx);
   endtask : instr

   // Programming frame; when busy is expected, follow status to ready.
   task automatic prog(input logic [1:0] op, input logic [8:0] a,
                       input logic [15:0] d, input int nd, input bit bsy);
      int n;
      host.frame_open();
      instr(op, a, d, nd);
      host.frame_close();
      if (bsy) begin
         check("busy after commit", 32'(rx[0]), 32'h0);
         host.frame_open();
         check("busy on reselect", 32'(do_line), 32'h0);
         n = 0;
         while (do_line !== 1'b1 && n < WCYC) begin
            @(negedge clk_in);
            n++;
         end
         check("ready in time", 32'(do_line), 32'h1);
         host.frame_close();
      end
   endtask : prog

   // Read nb bits from address a, checking dummy bit and release.
   task automatic rd(input logic [8:0] a, input int nb,
                     input logic [31:0] exp);
      host.frame_open();
      instr(OP_READ, a, 16'h0, 0);
      check("dummy bit", 32'(rx[0]), 32'h0);
      host.shift_bits(32'h0, nb, rx);
      check("read data", rx, exp);
      host.frame_close();
      check("released", 32'(oe), 32'h0);
   endtask : rd

   // The output stays released after reset with the pull-up default.
   task automatic t_reset();
      check("oe after reset", 32'(oe), 32'h0);
      $display("test reset done");
   endtask : t_reset

   // Enable, write two words, then read them in one sequential burst.
   task automatic t_write();
      prog(OP_EXT, ext(EXT_ENABLE), 16'h0, 0, 0);
      prog(OP_WRITE, 9'h012, 16'h1234, 16, 1);
      prog(OP_WRITE, 9'h013, 16'h5678, 16, 1);
      rd(9'h012, 32, 32'h12345678);
      $display("test write done");
   endtask : t_write

   // With programming disabled, write and erase leave the array alone.
   task automatic t_disabled();
      prog(OP_EXT, ext(EXT_DISABLE), 16'h0, 0, 0);
      prog(OP_WRITE, 9'h012, 16'hbeef, 16, 0);
      prog(OP_ERASE, 9'h013, 16'h0, 0, 0);
      rd(9'h012, 32, 32'h12345678);
      $display("test disabled done");
   endtask : t_disabled

   // Overwrite without erase first, then erase the next word.
   task automatic t_overwrite();
      prog(OP_EXT, ext(EXT_ENABLE), 16'h0, 0, 0);
      prog(OP_WRITE, 9'h012, 16'h3c5a, 16, 1);
      prog(OP_ERASE, 9'h013, 16'h0, 0, 1);
      rd(9'h012, 32, 32'h3c5affff);
      $display("test overwrite done");
   endtask : t_overwrite

   // Byte organisation: low byte first, then a byte write at the top.
   task automatic t_x8();
      strap_r = 1'b0;
      rd(9'h024, 16, 32'h5a3c);
      prog(OP_WRITE, 9'h1ff, 16'h0096, 8, 1);
      rd(9'h1ff, 8, 32'h96);
      $display("test x8 done");
   endtask : t_x8

   // Whole-array commands in byte mode, then a word read back in x16.
   task automatic t_all();
      prog(OP_EXT, ext(EXT_WRITE_ALL), 16'h00a5, 8, 1);
      rd(9'h000, 16, 32'ha5a5);
      prog(OP_EXT, ext(EXT_ERASE_ALL), 16'h0, 0, 1);
      rd(9'h1ff, 8, 32'hff);
      strap_r = 1'b1;
      rd(9'h0ff, 16, 32'hffff);
      prog(OP_EXT, ext(EXT_DISABLE), 16'h0, 0, 0);
      $display("test all done");
   endtask : t_all

   // Print the counts and the verdict, then stop.
   task automatic final_report();
      $display("Comparisons %0d, mismatches %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : final_report

   // Reset for two cycles, allow the pin sync, then run each scenario.
   initial begin
      repeat (2) @(negedge clk_in);
      sys_rst_in = 1'b0;
      repeat (3) @(negedge clk_in);
      t_reset();
      t_write();
      t_disabled();
      t_overwrite();
      t_x8();
      t_all();
      final_report();
   end
endmodule : swe_port_test
